// ==== bench/t2c_pulse_src.sv ====
// pulse source model for the three capture pins and the adc result line
// assumes calls come from one bench process, at a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module t2c_pulse_src (
  input  wire logic       clk_in,
  output logic      [3:0] pin_out
);
  initial pin_out = 4'h0;
  // bit 3 is the adc result; a level is held a whole number of clocks so
  // pulses and gaps never fall under the minimum width unless asked
  task automatic drive(input logic [3:0] m, input logic lvl, input int w);
    pin_out <= lvl ? (pin_out | m) : (pin_out & ~m);
    repeat (w) @(posedge clk_in);
  endtask : drive
endmodule : t2c_pulse_src
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the capture/compare timer block
// assumes the pulse source model on the capture pins and one 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import t2c_pkg::*;
;
  typedef struct {
    logic [1:0]  psc;
    logic        run;
    logic [15:0] diff;
  } t2c_row_s;
  // capture gap over one 64-clock pulse per prescale; last row frozen
  t2c_row_s    rows [5] = '{'{2'h0, 1'h1, 16'h0040}, '{2'h1, 1'h1, 16'h0010},
                            '{2'h2, 1'h1, 16'h0004}, '{2'h3, 1'h1, 16'h0002},
                            '{2'h0, 1'h0, 16'h0000}};
  logic        clk, srst, rd, wr, wq, cirq, tirq;
  logic [7:0]  adr;
  logic [31:0] wd, rdat, v, c0, j;
  logic [3:0]  pins;
  int          failures = 0;
  int          samples_checked = 0;

  t2c_timer_capture u_dut (
    .sys_clk_in            (clk),
    .srst_in               (srst),
    .avs_address_in        (adr),
    .avs_read_in           (rd),
    .avs_write_in          (wr),
    .avs_writedata_in      (wd),
    .avs_byteenable_in     (4'hF),
    .avs_readdata_out      (rdat),
    .avs_waitrequest_out   (wq),
    .capture_input_0_in    (pins[0]),
    .capture_input_1_in    (pins[1]),
    .capture_input_2_in    (pins[2]),
    .adc_compare_result_in (pins[3]),
    .capture_irq_out       (cirq),
    .timer_irq_out         (tirq)
  );
  t2c_pulse_src u_src (.clk_in(clk), .pin_out(pins));

  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : check

  // one Avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic w_en, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wd  <= d;
    wr  <= w_en;
    rd  <= ~w_en;
    // no local limit: a slave that never answers is ended by the watchdog
    do
      @(posedge clk);
    while (wq !== 1'h0);
    q = rdat;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask : bus

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d, j);
  endtask : wreg

  task automatic rreg(input logic [7:0] a);
    bus(1'h0, a, 32'h0, v);
  endtask : rreg

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    rreg(a);
    check(n, v & m, e);
  endtask : rchk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end

  initial
  begin
    srst = 1'h1;
    rd   = 1'h0;
    wr   = 1'h0;
    adr  = 8'h00;
    wd   = 32'h0;
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    check("wait", {31'h0, wq}, 32'h1);
    check("irq", {30'h0, cirq, tirq}, 32'h0);
    // includes the unmapped word just past the map
    for (int a = 0; a < 11; a++)
      rchk("reset", 8'(a * 4), 32'hFFFFFFFF, 32'h0);
    wreg(OFS_CAP0, 32'h0000FFFF);
    rchk("ro", OFS_CAP0, 32'hFFFF, 32'h0);
    $display("test reset done");
    foreach (rows[i])
    begin
      wreg(OFS_MODE, {30'h0, rows[i].psc});
      wreg(OFS_CAPCFG0, 32'h43);
      wreg(OFS_CTRL, {31'h0, rows[i].run});
      u_src.drive(4'h3, 1'h1, 64);
      u_src.drive(4'h3, 1'h0, 8);
      wreg(OFS_CTRL, 32'h0);
      rreg(OFS_CAP0);
      c0 = v;
      rreg(OFS_CAP1);
      check("gap", {16'h0, v[15:0] - c0[15:0]}, {16'h0, rows[i].diff});
    end
    $display("test prescale done");
    for (int e = 0; e < 4; e++)
    begin
      wreg(OFS_CAPCFG0, 32'(32'h4 | (e << 8)));
      wreg(OFS_COUNT, 32'(32'hA500 + e));
      wreg(OFS_CAPCFG1, 32'h70);
      u_src.drive(4'h4, 1'h1, 8);
      rchk("rise", OFS_CAPCFG1, 32'h70, (e != 1) ? 32'h40 : 32'h0);
      if (e != 1)
        rchk("cap", OFS_CAP2, 32'hFFFF, 32'(32'hA500 + e));
      wreg(OFS_CAPCFG1, 32'h70);
      u_src.drive(4'h4, 1'h0, 8);
      rchk("fall", OFS_CAPCFG1, 32'h70, (e != 0) ? 32'h40 : 32'h0);
    end
    $display("test edges done");
    wreg(OFS_CAPCFG0, 32'h201);
    wreg(OFS_CAPCFG1, 32'h71);
    u_src.drive(4'h5, 1'h1, 3);
    u_src.drive(4'h5, 1'h0, 8);
    rchk("filt", OFS_CAPCFG1, 32'h70, 32'h0);
    u_src.drive(4'h1, 1'h1, 8);
    rchk("filt", OFS_CAPCFG1, 32'h70, 32'h10);
    wreg(OFS_CAPCFG0, 32'h1001);
    wreg(OFS_CAPCFG1, 32'h70);
    u_src.drive(4'h1, 1'h0, 8);
    u_src.drive(4'h1, 1'h1, 8);
    rchk("adc", OFS_CAPCFG1, 32'h70, 32'h0);
    u_src.drive(4'h8, 1'h1, 8);
    rchk("adc", OFS_CAPCFG1, 32'h70, 32'h10);
    $display("test filter done");
    wreg(OFS_MODE, 32'h4);
    wreg(OFS_COUNT, 32'h0);
    wreg(OFS_RELOAD, 32'h20);
    wreg(OFS_IRQEN, 32'h3);
    wreg(OFS_CTRL, 32'h3);
    repeat (60) @(posedge clk);
    check("tirq", {31'h0, tirq}, 32'h1);
    rchk("match", OFS_CTRL, 32'h80, 32'h80);
    rreg(OFS_COUNT);
    check("cmax", {31'h0, v[15:0] <= 16'h20}, 32'h1);
    wreg(OFS_CTRL, 32'h80);
    repeat (3) @(posedge clk);
    check("tirq", {31'h0, tirq}, 32'h0);
    wreg(OFS_MODE, 32'h0);
    wreg(OFS_COUNT, 32'hFFF0);
    wreg(OFS_RELOAD, 32'h1234);
    wreg(OFS_CTRL, 32'h5);
    repeat (40) @(posedge clk);
    wreg(OFS_CTRL, 32'h0);
    rreg(OFS_COUNT);
    check("rld", {31'h0, v[15:0] >= 16'h1234 && v[15:0] < 16'h1260}, 32'h1);
    rchk("ovf", OFS_CTRL, 32'h80, 32'h80);
    wreg(OFS_CTRL, 32'h80);
    wreg(OFS_COUNT, 32'hFFF0);
    wreg(OFS_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    wreg(OFS_CTRL, 32'h0);
    rreg(OFS_COUNT);
    check("zero", {31'h0, v[15:0] < 16'h30}, 32'h1);
    $display("test modes done");
    wreg(OFS_CAPCFG0, 32'h2);
    wreg(OFS_CAPCFG1, 32'h70);
    wreg(OFS_IRQEN, 32'h1);
    wreg(OFS_COUNT, 32'h8000);
    wreg(OFS_RELOAD, 32'h0100);
    wreg(OFS_CTRL, 32'h25);
    u_src.drive(4'h2, 1'h1, 8);
    wreg(OFS_CTRL, 32'h0);
    rreg(OFS_COUNT);
    check("csrc", {31'h0, v[15:0] >= 16'h0100 && v[15:0] < 16'h0140}, 32'h1);
    check("cirq", {31'h0, cirq}, 32'h1);
    rchk("cflag", OFS_CAPCFG1, 32'h70, 32'h20);
    wreg(OFS_IRQEN, 32'h0);
    repeat (2) @(posedge clk);
    check("cirq", {31'h0, cirq}, 32'h0);
    wreg(OFS_MODE, 32'h8);
    wreg(OFS_COUNT, 32'h4000);
    wreg(OFS_CTRL, 32'h1);
    u_src.drive(4'h2, 1'h0, 4);
    u_src.drive(4'h2, 1'h1, 4);
    wreg(OFS_CTRL, 32'h0);
    rreg(OFS_COUNT);
    check("rcap", {31'h0, v[15:0] < 16'h10}, 32'h1);
    rreg(OFS_CAP1);
    check("rcapv", {31'h0, v[15:0] >= 16'h4000}, 32'h1);
    $display("test capture reload done");
    // reset in mid-run with a flag and a capture held; pin 1 still high
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    check("wait", {31'h0, wq}, 32'h1);
    rchk("rflag", OFS_CAPCFG1, 32'hFF, 32'h0);
    rchk("rcap", OFS_CAP1, 32'hFFFF, 32'h0);
    check("irq", {30'h0, cirq, tirq}, 32'h0);
    $display("test mid reset done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire

// ==== design/t2c_pkg.sv ====
// constants for the 16-bit capture/compare timer: register map, fields, reset values
// assumes a 32-bit Avalon-MM slave port with byte addresses
package t2c_pkg;
  localparam int          CNT_W         = 16;
  localparam int          NCH           = 3;
  localparam int          FILT_LEN      = 4;
  localparam int          ADDR_W        = 8;
  // register byte addresses
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_MODE      = 8'h04;
  localparam logic [7:0]  OFS_CAPCFG0   = 8'h08;
  localparam logic [7:0]  OFS_CAPCFG1   = 8'h0C;
  localparam logic [7:0]  OFS_COUNT     = 8'h10;
  localparam logic [7:0]  OFS_RELOAD    = 8'h14;
  localparam logic [7:0]  OFS_CAP0      = 8'h18;
  localparam logic [7:0]  OFS_CAP1      = 8'h1C;
  localparam logic [7:0]  OFS_CAP2      = 8'h20;
  localparam logic [7:0]  OFS_IRQEN     = 8'h24;
  // timer_control_reg fields
  localparam int          CTRL_RUN      = 0;
  localparam int          CTRL_CMPSEL   = 1;
  localparam int          CTRL_RFR      = 2;
  localparam int          CTRL_RSRC_LO  = 4;
  localparam int          CTRL_OVF      = 7;
  // timer_mode_reg fields
  localparam int          MODE_PSC_LO   = 0;
  localparam int          MODE_RST_MATCH = 2;
  localparam int          MODE_RST_CAP  = 3;
  // capture_config_0 fields
  localparam int          CFG0_EN_LO    = 0;
  localparam int          CFG0_EDGE_LO  = 4;
  localparam int          CFG0_SRC_ADC  = 12;
  // capture_config_1 fields
  localparam int          CFG1_FILT_LO  = 0;
  localparam int          CFG1_FLAG_LO  = 4;
  // irq enable fields
  localparam int          IRQ_CAP       = 0;
  localparam int          IRQ_TMR       = 1;
  // reset values and counter maximum
  localparam logic [15:0] RST_COUNT     = 16'h0000;
  localparam logic [15:0] RST_RELOAD    = 16'h0000;
  localparam logic [15:0] CNT_MAX       = 16'hFFFF;
  // prescale terminal counts for divide by 1, 4, 16, 32
  localparam logic [4:0]  PSC_TERM1     = 5'h00;
  localparam logic [4:0]  PSC_TERM4     = 5'h03;
  localparam logic [4:0]  PSC_TERM16    = 5'h0F;
  localparam logic [4:0]  PSC_TERM32    = 5'h1F;
  typedef enum logic [1:0] {
    T2C_EDGE_RISE = 2'b00,
    T2C_EDGE_FALL = 2'b01,
    T2C_EDGE_BOTH = 2'b10,
    T2C_EDGE_BOTH2 = 2'b11
  } t2c_edge_e;
endpackage : t2c_pkg

// ==== design/t2c_timer_capture.sv ====
// 16-bit up counter with three capture channels, compare and reload modes
// assumes an Avalon-MM master on one 20 MHz clock; capture inputs synchronous to it
//
// Contract
// - 16-bit up counter, low and high byte
// - counter clock divided by 1, 4, 16, 32
// - counter advances only while run bit set
// - three channels, own edge detectors, shared counter
// - filter needs four equal samples per edge
// - edge select: rising, falling or both
// - disabled channel neither captures nor reloads
// - channel 0 source pin or adc result
// - trigger copies count into capture register
// - capture sets flag; ORed flags gated interrupt
// - hardware sets flags, software clears them
// - reset-on-capture clears counter, beats counting
// - compare mode: match sets flag, restarts
// - reset-on-match clears counter after match
// - reload mode: overflow loads reload value
// - reload cleared: overflow loads zero
// - selected capture pin triggers reload, sets flag
`timescale 1ns/1ps
`default_nettype none
module t2c_timer_capture
  import t2c_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              srst_in,
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  input  wire logic              capture_input_0_in,
  input  wire logic              capture_input_1_in,
  input  wire logic              capture_input_2_in,
  input  wire logic              adc_compare_result_in,
  output logic                   capture_irq_out,
  output logic                   timer_irq_out
);

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction : be_merge

  function automatic logic edge_hit(input logic [1:0] sel, input logic lvl, input logic prv);
    logic rise;
    logic fall;
    rise = lvl & ~prv;
    fall = ~lvl & prv;
    case (sel)
      T2C_EDGE_RISE: edge_hit = rise;
      T2C_EDGE_FALL: edge_hit = fall;
      default:       edge_hit = rise | fall;
    endcase
  endfunction : edge_hit

  logic [6:0]       ctrl_r;
  // the overflow/match flag lives apart from the control bits so each has one writer
  logic             ovf_r;
  logic [3:0]       mode_r;
  logic [12:0]      cfg0_r;
  logic [2:0]       filt_en_r;
  logic [2:0]       flag_r;
  logic [1:0]       irqen_r;
  logic [15:0]      count_r;
  logic [15:0]      count_nxt;
  logic [15:0]      reload_r;
  logic [15:0]      cap_r [NCH];
  logic             wait_r;
  logic [4:0]       psc_r;
  logic [4:0]       psc_term;
  logic             tick;
  logic [NCH-1:0]   raw;
  logic [NCH-1:0]   lvl_r;
  logic [NCH-1:0]   prv_r;
  logic [NCH-1:0]   trig;
  logic [NCH-1:0]   rld_trig;
  logic [3:0]       samp_r [NCH];
  logic             bus_take;
  logic             wr_take;
  logic             match_ev;
  logic             ovf_ev;
  logic             sw_cnt_wr;

  // one wait state: request seen with wait_r high, completed on the next edge
  assign bus_take  = (avs_read_in | avs_write_in) & ~wait_r;
  assign wr_take   = avs_write_in & ~wait_r;
  assign sw_cnt_wr = wr_take && avs_address_in == OFS_COUNT;

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      wait_r <= 1'b1;
    else
      wait_r <= ~((avs_read_in | avs_write_in) & wait_r);
  end
  assign avs_waitrequest_out = wait_r;

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      avs_readdata_out <= 32'h0000_0000;
    else if (avs_read_in & wait_r)
      case (avs_address_in)
        OFS_CTRL:    avs_readdata_out <= {24'h00_0000, ovf_r, ctrl_r};
        OFS_MODE:    avs_readdata_out <= {28'h000_0000, mode_r};
        OFS_CAPCFG0: avs_readdata_out <= {19'h0_0000, cfg0_r};
        OFS_CAPCFG1: avs_readdata_out <= {25'h000_0000, flag_r, 1'b0, filt_en_r};
        OFS_COUNT:   avs_readdata_out <= {16'h0000, count_r};
        OFS_RELOAD:  avs_readdata_out <= {16'h0000, reload_r};
        OFS_CAP0:    avs_readdata_out <= {16'h0000, cap_r[0]};
        OFS_CAP1:    avs_readdata_out <= {16'h0000, cap_r[1]};
        OFS_CAP2:    avs_readdata_out <= {16'h0000, cap_r[2]};
        OFS_IRQEN:   avs_readdata_out <= {30'h0000_0000, irqen_r};
        default:     avs_readdata_out <= 32'h0000_0000;
      endcase
  end

  // configuration registers
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      ctrl_r      <= 7'h00;
      mode_r      <= 4'h0;
      cfg0_r      <= 13'h0000;
      filt_en_r   <= 3'h0;
      reload_r    <= RST_RELOAD;
      irqen_r     <= 2'h0;
    end
    else if (wr_take)
      case (avs_address_in)
        OFS_CTRL:    ctrl_r      <= 7'(be_merge({25'h0, ctrl_r}, avs_writedata_in,
                                                avs_byteenable_in) & 32'h0000_0037);
        OFS_MODE:    mode_r      <= 4'(be_merge({28'h0, mode_r}, avs_writedata_in,
                                                avs_byteenable_in));
        OFS_CAPCFG0: cfg0_r      <= 13'(be_merge({19'h0, cfg0_r}, avs_writedata_in,
                                                 avs_byteenable_in) & 32'h0000_13F7);
        OFS_CAPCFG1: filt_en_r   <= avs_byteenable_in[0] ? avs_writedata_in[2:0] : filt_en_r;
        OFS_RELOAD:  reload_r    <= 16'(be_merge({16'h0, reload_r}, avs_writedata_in,
                                                 avs_byteenable_in));
        OFS_IRQEN:   irqen_r     <= avs_byteenable_in[0] ? avs_writedata_in[1:0] : irqen_r;
        default:     ;
      endcase
  end

  // prescaler: one-cycle tick every 1, 4, 16 or 32 clocks
  always_comb
  begin
    case (mode_r[MODE_PSC_LO +: 2])
      2'b00:   psc_term = PSC_TERM1;
      2'b01:   psc_term = PSC_TERM4;
      2'b10:   psc_term = PSC_TERM16;
      default: psc_term = PSC_TERM32;
    endcase
  end
  assign tick = (psc_r >= psc_term);

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || !ctrl_r[CTRL_RUN])
      psc_r <= 5'h00;
    else if (tick)
      psc_r <= 5'h00;
    else
      psc_r <= psc_r + 5'h01;
  end

  // capture channels
  assign raw[0] = cfg0_r[CFG0_SRC_ADC] ? adc_compare_result_in : capture_input_0_in;
  assign raw[1] = capture_input_1_in;
  assign raw[2] = capture_input_2_in;

  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    always_ff @(posedge sys_clk_in)
    begin
      if (srst_in)
      begin
        samp_r[i] <= 4'h0;
        lvl_r[i]  <= 1'b0;
        prv_r[i]  <= 1'b0;
      end
      else
      begin
        samp_r[i] <= {samp_r[i][2:0], raw[i]};
        prv_r[i]  <= lvl_r[i];
        if (!filt_en_r[i])
          lvl_r[i] <= raw[i];
        else if (samp_r[i] == 4'hF)
          lvl_r[i] <= 1'b1;
        else if (samp_r[i] == 4'h0)
          lvl_r[i] <= 1'b0;
      end
    end
    // each channel has its own detector on its own filtered level
    assign trig[i] = cfg0_r[CFG0_EN_LO + i] &
                     edge_hit(cfg0_r[CFG0_EDGE_LO + 2*i +: 2], lvl_r[i], prv_r[i]);
    assign rld_trig[i] = trig[i] && ctrl_r[CTRL_RSRC_LO +: 2] == 2'(i + 1);

    always_ff @(posedge sys_clk_in)
    begin
      if (srst_in)
        cap_r[i] <= RST_COUNT;
      else if (trig[i])
        cap_r[i] <= count_r;
    end
  end

  // flags: a set in the same cycle as a software clear wins
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      flag_r <= 3'h0;
      ovf_r  <= 1'b0;
    end
    else
    begin
      flag_r <= trig | (flag_r & ~((wr_take && avs_address_in == OFS_CAPCFG1 &&
                avs_byteenable_in[0]) ? avs_writedata_in[CFG1_FLAG_LO +: 3] : 3'h0));
      ovf_r  <= match_ev | ovf_ev | (ovf_r &
                ~(wr_take && avs_address_in == OFS_CTRL && avs_byteenable_in[0] &&
                  avs_writedata_in[CTRL_OVF]));
    end
  end

  assign match_ev = tick & ctrl_r[CTRL_RUN] & ctrl_r[CTRL_CMPSEL] & (count_r == reload_r);
  assign ovf_ev   = tick & ctrl_r[CTRL_RUN] & ~ctrl_r[CTRL_CMPSEL] & (count_r == CNT_MAX);

  // counter: software write, capture reset, capture reload, then counting
  always_comb
  begin
    count_nxt = count_r;
    if (sw_cnt_wr)
      count_nxt = 16'(be_merge({16'h0, count_r}, avs_writedata_in, avs_byteenable_in));
    else if (mode_r[MODE_RST_CAP] && |trig)
      count_nxt = RST_COUNT;
    else if (|rld_trig)
      count_nxt = ctrl_r[CTRL_RFR] ? reload_r : RST_COUNT;
    else if (tick && ctrl_r[CTRL_RUN])
    begin
      if (match_ev)
        count_nxt = RST_COUNT;
      else if (ovf_ev)
        count_nxt = ctrl_r[CTRL_RFR] ? reload_r : RST_COUNT;
      else
        count_nxt = count_r + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      count_r <= RST_COUNT;
    else
      count_r <= count_nxt;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      capture_irq_out <= 1'b0;
      timer_irq_out   <= 1'b0;
    end
    else
    begin
      capture_irq_out <= (|flag_r) & irqen_r[IRQ_CAP];
      timer_irq_out   <= ovf_r & irqen_r[IRQ_TMR];
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  logic quiet;
  assign quiet = ~sw_cnt_wr & ~(|trig);

  sequence s_div4_gap;
    // stopping the timer inside the gap clears the prescaler, so no tick follows
    !tick [*3] ##1 (tick || !ctrl_r[CTRL_RUN]);
  endsequence

  sequence s_four_high(int k);
    raw[k] [*4];
  endsequence

  cap_latch_a: assert property (trig[1] |=> cap_r[1] == $past(count_r))
    else $error("capture register missed the count");
  flag_set_a: assert property (trig[2] |=> flag_r[2])
    else $error("capture flag not set by trigger");
  irq_gate_a: assert property (flag_r[0] && irqen_r[IRQ_CAP] |=> capture_irq_out)
    else $error("capture interrupt not raised");
  run_hold_a: assert property (!ctrl_r[CTRL_RUN] && quiet |=> $stable(count_r))
    else $error("stopped counter moved");
  cap_reset_a: assert property (mode_r[MODE_RST_CAP] && (|trig) && !sw_cnt_wr
    |=> count_r == RST_COUNT)
    else $error("counter not cleared after capture");
  match_restart_a: assert property (match_ev && quiet
    |=> count_r == RST_COUNT && ovf_r)
    else $error("compare match did not restart counter");
  reload_val_a: assert property (ovf_ev && ctrl_r[CTRL_RFR] && quiet
    |=> count_r == $past(reload_r))
    else $error("overflow did not load reload value");
  reload_zero_a: assert property (ovf_ev && !ctrl_r[CTRL_RFR] && quiet
    |=> count_r == RST_COUNT)
    else $error("overflow did not load zero");
  psc_div4_a: assert property (tick && ctrl_r[CTRL_RUN] && mode_r[1:0] == 2'b01
    && $stable(mode_r) |-> ##1 s_div4_gap)
    else $error("divide by four tick spacing wrong");
  filt_rise_a: assert property (filt_en_r[0] && !lvl_r[0] && $stable(filt_en_r)
    ##1 s_four_high(0) |=> ##1 lvl_r[0])
    else $error("filter did not follow four equal samples");
  count_step_a: assert property (tick && ctrl_r[CTRL_RUN] && !match_ev && !ovf_ev
    && quiet && rld_trig == 3'h0 |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not step by one");

endmodule : t2c_timer_capture
`default_nettype wire
